// ==== logic/itb_decoder.v ====
/*
  Decoder and execute control for the if-then prefix, table branches
  and breakpoint. Assumes one instruction presented per valid cycle
  with operands already read, and an exception unit that saves and
  restores the block state word on entry and return.
*/
// Overview of operation
// RULE1 - Prefix conditions one to four following instructions
// RULE2 - Later slots use base or inverted condition
// RULE3 - Always base forbids Else slots (not checked: an AL block runs its Else slots too)
// RULE4 - Block instructions carry matching condition suffix
// RULE5 - Breakpoint in block always executes
// RULE6 - Exceptions save block state for return
// RULE7 - Exception return restores remaining block conditions
// RULE8 - No prefix, compare branch, interrupt ops inside (not checked: an IT inside only uses up a slot)
// RULE9 - PC writers only last in block (not checked: branches are taken in any slot)
// RULE10 - Conditional non-branch instructions only inside blocks
// RULE11 - Conditional branch gets larger range inside
// RULE12 - Block conditions are base or its inverse
// RULE13 - Table offset is twice unsigned entry
// RULE14 - Target is next address plus offset
// RULE15 - PC base means address after instruction
// RULE16 - Halfword variant shifts index left one
// RULE17 - Table base not SP, index not SP/PC (not checked: any base and index register is accepted)
// RULE18 - Table branch only last in block (not checked: taken in any slot)
// RULE19 - Breakpoint enters debug state
// RULE20 - Breakpoint immediate ignored by processor
// RULE21 - Indirect branch faults when target bit0 clear
// RULE22 - Block state holds condition and slot mask
`timescale 1ns/10ps
`include "itb_consts.vh"
module itb_decoder #(
  parameter AW = 32
) (
  // Clock and control
  input  wire          clk_sys,
  input  wire          srst,
  input  wire          clk_en,
  // Instruction in
  input  wire          ins_valid,
  input  wire [15:0]   ins_hw0,
  input  wire [15:0]   ins_hw1,
  input  wire          ins_wide,
  input  wire [AW-1:0] ins_addr,
  input  wire [3:0]    flags_nzcv,
  // Operands
  input  wire [AW-1:0] table_base_val,
  input  wire [AW-1:0] table_index_val,
  input  wire [15:0]   table_entry,
  input  wire [AW-1:0] bx_target,
  input  wire [AW-1:0] bc_offset,
  // Exception interface
  input  wire          exc_entry,
  input  wire          exc_return,
  input  wire [7:0]    exc_state_in,
  // Outputs
  output reg  [7:0]    blk_state_q,
  output reg  [7:0]    saved_state_q,
  output reg           exec_en_q,
  output reg           in_block_q,
  output reg           tb_fetch_q,
  output reg  [AW-1:0] tb_addr_q,
  output reg           branch_q,
  output reg  [AW-1:0] branch_tgt_q,
  output reg           usage_fault_q,
  output reg           debug_halt_q
);

  wire [3:0] base_cond = blk_state_q[7:4];
  wire       active    = (blk_state_q[3:0] != 4'h0);

  function cond_pass;
    input [3:0] c;
    input [3:0] f;
    reg r;
    begin
      case (c[3:1])
        3'h0: r = f[2];
        3'h1: r = f[1];
        3'h2: r = f[3];
        3'h3: r = f[0];
        3'h4: r = f[1] & ~f[2];
        3'h5: r = (f[3] == f[0]);
        3'h6: r = ~f[2] & (f[3] == f[0]);
        default: r = 1'b1;
      endcase
      cond_pass = (c[3:1] == 3'h7) ? 1'b1 : (r ^ c[0]);
    end
  endfunction

  wire is_it   = ((ins_hw0 & `ITB_IT_MASK) == `ITB_IT_MATCH) &
                 (ins_hw0[3:0] != 4'h0) & ~ins_wide;
  wire is_breakpoint_op = ((ins_hw0 & `ITB_BREAKPOINT_OP_MASK) == `ITB_BREAKPOINT_OP_MATCH) &
                 ~ins_wide;
  wire is_tb   = ins_wide &
                 ((ins_hw0 & `ITB_TB_MASK) == `ITB_TB_MATCH) &
                 ((ins_hw1 & `ITB_TB2_MASK) == `ITB_TB2_MATCH);
  wire tb_half = ins_hw1[`ITB_TB_H_BIT];
  wire is_bc   = ((ins_hw0 & `ITB_BC_MASK) == `ITB_BC_MATCH) &
                 (ins_hw0[11:9] != 3'h7) & ~ins_wide;
  wire is_bx   = ((ins_hw0 & `ITB_BX_MASK) == `ITB_BX_MATCH) & ~ins_wide;

  // RULE2 current slot condition
  wire [3:0] slot_cond = {base_cond[3:1], blk_state_q[4]};
  wire       pass = active ? cond_pass(slot_cond, flags_nzcv) : 1'b1;
  // RULE5 breakpoint ignores slot
  wire       exec = pass | is_breakpoint_op;

  // Instruction lengths in bytes, sized to the address width
  localparam [AW-1:0] LEN_NARROW = 2;
  localparam [AW-1:0] LEN_WIDE   = 4;

  wire [AW-1:0] next_addr = ins_addr + (ins_wide ? LEN_WIDE : LEN_NARROW);
  // RULE15 PC base
  wire [3:0]    tb_rn   = ins_hw0[3:0];
  wire [AW-1:0] tb_base = (tb_rn == `ITB_REG_PC) ? next_addr
                                                 : table_base_val;
  // RULE16 halfword index shift
  wire [AW-1:0] tb_idx  = tb_half ? {table_index_val[AW-2:0], 1'b0}
                                  : table_index_val;
  // RULE13 unsigned doubled entry
  wire [15:0]   entry   = tb_half ? table_entry
                                  : {8'h00, table_entry[7:0]};
  wire [AW-1:0] tb_off  = {{(AW-17){1'b0}}, entry, 1'b0};
  // RULE11 wider range in block
  wire [AW-1:0] bc_lim  = active ?
    {{(AW-`ITB_BC_IN_BITS){bc_offset[`ITB_BC_IN_BITS-1]}},
     bc_offset[`ITB_BC_IN_BITS-1:0]} :
    {{(AW-`ITB_BC_OUT_BITS){bc_offset[`ITB_BC_OUT_BITS-1]}},
     bc_offset[`ITB_BC_OUT_BITS-1:0]};
  wire bc_pass = active ? pass :
                 cond_pass(ins_hw0[11:8], flags_nzcv);

  // RULE22 advance slot mask
  wire [7:0] adv = (blk_state_q[2:0] == 3'h0) ? `ITB_STATE_RST :
                   {blk_state_q[7:5], blk_state_q[3:0], 1'b0};

  reg [7:0] state_d;
  always @* begin
    state_d = blk_state_q;
    if (exc_return) begin
      // RULE7 restore block state
      state_d = saved_state_q;
    end else if (ins_valid) begin
      if (is_it & ~active) begin
        // RULE1 load condition and mask
        state_d = ins_hw0[7:0];
      end else if (active) begin
        state_d = adv;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      blk_state_q   <= `ITB_STATE_RST;
      saved_state_q <= `ITB_STATE_RST;
      exec_en_q     <= 1'b0;
      in_block_q    <= 1'b0;
      tb_fetch_q    <= 1'b0;
      tb_addr_q     <= {AW{1'b0}};
      branch_q      <= 1'b0;
      branch_tgt_q  <= {AW{1'b0}};
      usage_fault_q <= 1'b0;
      debug_halt_q  <= 1'b0;
    end else if (clk_en) begin
      // RULE6 save state on exception
      if (exc_entry) begin
        saved_state_q <= blk_state_q;
      end else if (exc_return) begin
        saved_state_q <= exc_state_in;
      end
      blk_state_q   <= exc_entry ? blk_state_q : state_d;
      in_block_q    <= active;
      exec_en_q     <= ins_valid & ~exc_entry & exec;
      tb_fetch_q    <= 1'b0;
      branch_q      <= 1'b0;
      usage_fault_q <= 1'b0;
      debug_halt_q  <= 1'b0;
      if (ins_valid & ~exc_entry & ~exc_return) begin
        if (is_tb & pass) begin
          tb_fetch_q <= 1'b1;
          tb_addr_q  <= tb_base + tb_idx;
          // RULE14 target after instruction
          branch_q     <= 1'b1;
          branch_tgt_q <= next_addr + tb_off;
        end
        if (is_bc & bc_pass) begin
          branch_q     <= 1'b1;
          branch_tgt_q <= next_addr + LEN_NARROW + bc_lim;
        end
        if (is_bx & pass) begin
          // RULE21 bit0 check
          usage_fault_q <= ~bx_target[0];
          branch_q      <= bx_target[0];
          branch_tgt_q  <= {bx_target[AW-1:1], 1'b0};
        end
        // RULE19 RULE20 debug entry, immediate unused
        if (is_breakpoint_op) begin
          debug_halt_q <= 1'b1;
        end
      end
    end
  end

endmodule

// ==== logic/itb_consts.vh ====
/*
  Constants for the if-then, table branch and breakpoint decoder.
  Assumes a 16-bit instruction halfword stream from fetch.
*/
`ifndef ITB_CONSTS_VH
`define ITB_CONSTS_VH
// Opcode matches on the first halfword, TB2 on the second
`define ITB_IT_MASK      16'hff00
`define ITB_IT_MATCH     16'hbf00
`define ITB_BREAKPOINT_OP_MASK    16'hff00
`define ITB_BREAKPOINT_OP_MATCH   16'hbe00
`define ITB_TB_MASK      16'hfff0
`define ITB_TB_MATCH     16'he8d0
`define ITB_TB2_MASK     16'hffe0
`define ITB_TB2_MATCH    16'hf000
`define ITB_BC_MASK      16'hf000
`define ITB_BC_MATCH     16'hd000
`define ITB_BX_MASK      16'hff07
`define ITB_BX_MATCH     16'h4700
// Field positions
`define ITB_COND_MSB     7
`define ITB_COND_LSB     4
`define ITB_TB_H_BIT     4
// Register and condition codes
`define ITB_REG_PC       4'hf
`define ITB_COND_AL      4'he
// Branch range offset widths, outside and inside a block
`define ITB_BC_OUT_BITS  21
`define ITB_BC_IN_BITS   25
// Execution state reset value
`define ITB_STATE_RST    8'h00
`endif

// ==== sim/itb_exc_model.sv ====
/* Exception unit stand-in: stacks the saved block state.
   Assumes the bench drives the entry and return pulses. */
`timescale 1ns/10ps
module itb_exc_model (
  input  wire       clk_sys, srst, exc_entry,
  input  wire [7:0] saved_state_q,
  output reg  [7:0] exc_state_in
);
  always @(posedge clk_sys) begin
    if (srst) exc_state_in <= 8'h00;
    else if (exc_entry) exc_state_in <= saved_state_q;
  end
endmodule

// ==== sim/itb_monitor.sv ====
/* Port checker for the decoder, attached by bind.
   Assumes one clock domain and synchronous reset. */
`timescale 1ns/10ps
module itb_monitor #(parameter AW = 32) (
  input wire          clk_sys, srst, clk_en, ins_valid, exc_entry, exc_return,
  input wire [15:0]   ins_hw0, ins_hw1, table_entry,
  input wire [AW-1:0] ins_addr, table_base_val, table_index_val, bx_target,
  input wire [AW-1:0] tb_addr_q, branch_tgt_q,
  input wire [7:0]    blk_state_q, saved_state_q,
  input wire          exec_en_q, tb_fetch_q, branch_q, usage_fault_q,
  input wire          debug_halt_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire go = ins_valid & clk_en & ~exc_entry & ~exc_return;
  wire blk = blk_state_q[3:0] != 4'h0;
  wire tb = go & ~blk & ins_hw0[15:4] == 12'he8d & ins_hw1[15:5] == 11'h780;
  wire hw = ins_hw1[4];
  wire [AW-1:0] nxt = ins_addr + 4;
  wire [AW-1:0] base = ins_hw0[3:0] == 4'hf ? nxt : table_base_val;
  wire [AW-1:0] taddr = base + (hw ? table_index_val << 1 : table_index_val);
  wire [15:0] ent = hw ? table_entry : {8'h00, table_entry[7:0]};
  wire [AW-1:0] tgt = nxt + {ent, 1'b0};
  wire [7:0] adv = blk_state_q[2:0] == 3'h0 ? 8'h00
                 : {blk_state_q[7:5], blk_state_q[4:0] << 1};
  sequence s_it;
    go && !blk && ins_hw0[15:8] == 8'hbf && ins_hw0[3:0] != 4'h0;
  endsequence
  it_load_a: assert property (s_it |=> blk_state_q == $past(ins_hw0[7:0]))
    else $error("prefix state wrong");
  blk_adv_a: assert property (go && blk |=> blk_state_q == $past(adv))
    else $error("slot advance wrong");
  breakpoint_op_halt_a: assert property (go && ins_hw0[15:8] == 8'hbe
    |=> debug_halt_q && exec_en_q) else $error("breakpoint not taken");
  exc_save_a: assert property (exc_entry && clk_en
    |=> saved_state_q == $past(blk_state_q) && $stable(blk_state_q))
    else $error("entry save wrong");
  exc_ret_a: assert property (exc_return && clk_en && !exc_entry
    |=> blk_state_q == $past(saved_state_q)) else $error("return wrong");
  tb_tgt_a: assert property (tb |=> branch_q && branch_tgt_q == $past(tgt))
    else $error("table target wrong");
  tb_addr_a: assert property (tb |=> tb_fetch_q && tb_addr_q == $past(taddr))
    else $error("table address wrong");
  bx_fault_a: assert property (go && !blk && (ins_hw0 & 16'hff07) == 16'h4700
    && !bx_target[0] |=> usage_fault_q && !branch_q) else $error("no fault");
endmodule
bind itb_decoder itb_monitor #(.AW(AW)) i_itb_monitor (.*);

// ==== sim/itb_decoder_tb.sv ====
/* Directed bench for the decoder.
   Assumes outputs settle within 1 ns of the taking edge. */
`timescale 1ns/10ps
`define CHK(n,e,v) tests_run++; if ((v) !== (e)) begin $display("[FAIL] %s exp %h got %h", n, e, v); err_count++; end
module itb_decoder_tb;
  reg         clk_sys, srst, clk_en, ins_valid, ins_wide, exc_entry, exc_return;
  reg  [15:0] ins_hw0, ins_hw1, table_entry;
  reg  [31:0] ins_addr, table_base_val, table_index_val, bx_target, bc_offset;
  reg  [3:0]  flags_nzcv;
  wire [7:0]  blk_state_q, saved_state_q, exc_state_in;
  wire [31:0] tb_addr_q, branch_tgt_q;
  wire        exec_en_q, in_block_q, tb_fetch_q, branch_q, usage_fault_q;
  wire        debug_halt_q;
  integer     err_count = 0, tests_run = 0;
  itb_decoder i_itb_decoder (.*);
  itb_exc_model i_itb_exc_model (.*);
  task op(input [15:0] h0, input [15:0] h1); begin
    ins_hw0 = h0; ins_hw1 = h1; ins_wide = h0[15:13] == 3'h7; ins_valid = 1;
    @(posedge clk_sys); #1;
  end endtask
  task pulse(input e, input r); begin
    ins_valid = 0; exc_entry = e; exc_return = r;
    @(posedge clk_sys); #1;
    exc_entry = 0; exc_return = 0;
  end endtask
  task t_block; begin
    op(16'hbf06, 0); `CHK("st", 8'h06, blk_state_q)
    op(16'h4608, 0); `CHK("st", 8'h0c, blk_state_q)
    `CHK("ib", 1'b1, in_block_q)
    op(16'h4608, 0); `CHK("ex", 1'b1, exec_en_q)
    op(16'hbeff, 0); `CHK("ex", 1'b1, exec_en_q)
    `CHK("dbg", 1'b1, debug_halt_q)
    `CHK("st", 8'h00, blk_state_q)
    op(16'hbf18, 0); op(16'h4608, 0); `CHK("ex", 1'b0, exec_en_q)
    op(16'hbe00, 0); `CHK("dbg", 1'b1, debug_halt_q)
  end endtask
  task t_table; begin
    op(16'he8d0, 16'hf001); `CHK("ta", 32'h1003, tb_addr_q)
    `CHK("tf", 1'b1, tb_fetch_q)
    `CHK("br", 1'b1, branch_q)
    `CHK("tg", 32'h26c, branch_tgt_q)
    op(16'he8df, 16'hf011); `CHK("ta", 32'h20a, tb_addr_q)
    `CHK("tg", 32'h266c, branch_tgt_q)
  end endtask
  task t_bx; begin
    op(16'h4708, 0); `CHK("bt", 32'h300, branch_tgt_q)
    bx_target = 32'h300;
    op(16'h4708, 0); `CHK("uf", 1'b1, usage_fault_q)
  end endtask
  task t_bc; begin
    bc_offset = 32'h0010_0000;
    op(16'hd000, 0); `CHK("bc", 32'hfff0_0204, branch_tgt_q)
    op(16'hbf08, 0); op(16'hd000, 0);
    `CHK("bc", 32'h0010_0204, branch_tgt_q)
  end endtask
  task t_exc; begin
    op(16'hbf06, 0); op(16'h4608, 0); pulse(1, 0);
    `CHK("sv", 8'h0c, saved_state_q)
    pulse(0, 1); `CHK("st", 8'h0c, blk_state_q)
    `CHK("sv", 8'h00, saved_state_q)
    op(16'h4608, 0); `CHK("st", 8'h18, blk_state_q)
  end endtask
  task summarize; begin
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000; err_count++; summarize;
  end
  initial begin
    srst = 1; clk_en = 1; ins_valid = 0; ins_wide = 0; exc_entry = 0;
    exc_return = 0; ins_hw0 = 0; ins_hw1 = 0; table_entry = 16'h1234;
    ins_addr = 32'h200; table_base_val = 32'h1000; table_index_val = 3;
    bx_target = 32'h301; flags_nzcv = 4'h4; bc_offset = 0;
    repeat (16) @(posedge clk_sys);
    #1 srst = 0;
    t_block; t_table; t_bx; t_bc; t_exc;
    summarize;
  end
endmodule
